// >>> pmc_device.sv
`timescale 1ns/1ps
module pmc_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_r] <= in_data;
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module pmc_device
    import pmc_pkg::*;
#(
    parameter pmc_rate_tbl_t DATA_US = DATA_US_DFLT,
    parameter pmc_rate_tbl_t DIAG_US = DIAG_US_DFLT
) (
    input wire logic clk,
    input wire logic reset_n,
    pmc_link_if.dev link,
    input wire logic [ID_W-1:0] default_config_identifier,
    input wire logic [SER_W-1:0] own_serial,
    input wire logic samp_valid,
    output logic samp_ready,
    input wire logic [DATA_W-1:0] samp_data,
    input wire logic [DATA_W-1:0] diag_data,
    output logic sample_start,
    output logic configured,
    output logic [ID_W-1:0] global_data_identifier
);
    logic strap_taken_r;
    logic [ID_W-1:0] cfg_id_r;
    logic configured_r;
    logic diag_en_r;
    logic rtr_mode_r;
    logic [RATE_W-1:0] rate_r;
    logic [ID_W-1:0] base_r;
    logic [TICK_W-1:0] tick_r;
    logic [TMR_W-1:0] dt_r;
    logic [TMR_W-1:0] gt_r;
    logic send_pend_r;
    logic diag_pend_r;
    logic [MUX_W-1:0] mux_r;
    logic coh_r;
    pmc_tx_t st_r;
    pmc_tx_t st_nxt;
    logic [ID_W-1:0] tx_id_r;
    logic [DATA_W-1:0] tx_data_r;
    logic sample_start_r;
    logic f_valid;
    logic f_ready;
    logic [DATA_W-1:0] f_data;

    pmc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(samp_valid),
        .in_ready(samp_ready),
        .in_data(samp_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // microsecond tick, one bit time at 1 Mbps
    wire tick = (tick_r == TICK_LAST);

    // receive decode; frames are always taken
    assign link.h2d_ready = 1'b1;
    wire rx_fire = link.h2d_valid;
    wire [SER_W-1:0] rx_ser = link.h2d_data[SER_LSB +: SER_W];
    wire [ID_W-1:0] rx_base = {link.h2d_data[BASE_HI_LSB +: 3],
                               link.h2d_data[BASE_LO_LSB +: 8]};
    wire ser_ok = (rx_ser == own_serial)
                  || (rx_ser == '0 && !configured_r);
    wire cfg_hit = rx_fire && !link.h2d_rtr && strap_taken_r
                   && (link.h2d_id == cfg_id_r);
    wire accept = cfg_hit && ser_ok;
    wire rtr_hit = rx_fire && link.h2d_rtr && configured_r && rtr_mode_r
                   && (link.h2d_id == base_r);

    // periods from the rate table
    wire [TMR_W-1:0] base_us = DATA_US[rate_r];
    wire [TMR_W+2:0] stretched = ((TMR_W+3)'(base_us) * (TMR_W+3)'(STRETCH_NUM))
                                 / (TMR_W+3)'(STRETCH_DEN);
    wire [TMR_W-1:0] data_us = rtr_mode_r ? stretched[TMR_W-1:0] : base_us;
    wire [TMR_W-1:0] diag_us = DIAG_US[rate_r];
    wire data_due = configured_r && tick && (dt_r >= data_us - 1'b1);
    wire diag_due = configured_r && diag_en_r && tick
                    && (gt_r >= diag_us - 1'b1);

    // transmit sequencing
    wire tx_fire = link.d2h_valid && link.d2h_ready;
    wire set_go = (st_r == TX_IDLE) && f_valid && (send_pend_r || mux_r != '0);
    wire diag_go = (st_r == TX_IDLE) && !set_go && diag_pend_r;
    wire set_done = tx_fire && (st_r == TX_DATA) && (mux_r == MUX_LAST);
    assign f_ready = set_go;
    wire [DATA_W-1:0] frame_a = {coh_r, f_data[COH_BIT-1:MUX_W], mux_r};
    wire [DATA_W-1:0] frame_b = {frame_a[DATA_W-1:SERIAL_LSB+SER_W], own_serial,
                                 frame_a[SERIAL_LSB-1:0]};
    wire [DATA_W-1:0] frame = (mux_r == MUX_SERIAL) ? frame_b : frame_a;

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            TX_IDLE:
            begin
                if (set_go)
                    st_nxt = TX_DATA;
                else if (diag_go)
                    st_nxt = TX_DIAG;
            end
            TX_DATA,
            TX_DIAG:
            begin
                if (tx_fire)
                    st_nxt = TX_IDLE;
            end
            default:
                st_nxt = TX_IDLE;
        endcase
    end

    assign link.d2h_valid = (st_r != TX_IDLE);
    assign link.d2h_id = tx_id_r;
    assign link.d2h_data = tx_data_r;
    assign sample_start = sample_start_r;
    assign configured = configured_r;
    assign global_data_identifier = base_r;

    // default identifier is caught once, just after reset release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            strap_taken_r <= 1'b0;
            cfg_id_r <= CFG_ID_DFLT;
        end
        else if (!strap_taken_r)
        begin
            strap_taken_r <= 1'b1;
            cfg_id_r <= default_config_identifier;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            configured_r <= 1'b0;
            diag_en_r <= 1'b0;
            rtr_mode_r <= 1'b0;
            rate_r <= '0;
            base_r <= '0;
        end
        else if (accept)
        begin
            configured_r <= 1'b1;
            diag_en_r <= link.h2d_data[DIAG_EN_BIT];
            rtr_mode_r <= link.h2d_data[RTR_EN_BIT];
            rate_r <= link.h2d_data[RATE_LSB +: RATE_W];
            base_r <= rx_base;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_r <= '0;
            dt_r <= '0;
            gt_r <= '0;
        end
        else
        begin
            tick_r <= tick ? '0 : tick_r + 1'b1;
            // remote request restarts the fallback interval
            if (accept || rtr_hit || data_due)
                dt_r <= '0;
            else if (tick)
                dt_r <= dt_r + 1'b1;
            if (accept || diag_due)
                gt_r <= '0;
            else if (tick)
                gt_r <= gt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            send_pend_r <= 1'b0;
            diag_pend_r <= 1'b0;
            sample_start_r <= 1'b0;
        end
        else
        begin
            // a new trigger wins over the clear of a start
            send_pend_r <= data_due || rtr_hit
                           || (send_pend_r && !(set_go && mux_r == '0));
            diag_pend_r <= diag_due || (diag_pend_r && !diag_go);
            sample_start_r <= accept || data_due
                              || (rtr_mode_r && set_done);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= TX_IDLE;
            mux_r <= '0;
            coh_r <= 1'b0;
            tx_id_r <= '0;
            tx_data_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            if (set_go)
            begin
                tx_id_r <= base_r;
                tx_data_r <= frame;
            end
            else if (diag_go)
            begin
                tx_id_r <= base_r + DIAG_ID_OFS;
                tx_data_r <= diag_data;
            end
            if (tx_fire && st_r == TX_DATA)
                mux_r <= mux_r + 1'b1;
            if (set_done)
                coh_r <= ~coh_r;
        end
    end
endmodule

// >>> pmc_pkg.sv
package pmc_pkg;
    // link timing: 1 Mbps, 11-bit identifiers
    localparam int CLK_NS = 50;
    localparam int BIT_NS = 1000;
    localparam int CYC_PER_BIT = (BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W = 5;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYC_PER_BIT - 1);
    localparam int ID_W = 11;
    localparam int DATA_W = 64;
    localparam int FIFO_DEPTH = 8;
    localparam int TMR_W = 24;
    localparam logic [ID_W-1:0] CFG_ID_DFLT = 11'h130;
    // configuration frame layout, byte 0 in data[7:0]
    localparam int SER_LSB = 0;
    localparam int SER_W = 32;
    localparam int DIAG_EN_BIT = 32;
    localparam int RTR_EN_BIT = 33;
    localparam int RATE_LSB = 34;
    localparam int RATE_W = 3;
    localparam int BASE_LO_LSB = 40;
    localparam int BASE_HI_LSB = 48;
    // sampled-data frame layout
    localparam int MUX_LSB = 0;
    localparam int MUX_W = 2;
    localparam int SERIAL_LSB = 13;
    localparam int COH_BIT = 63;
    localparam logic [MUX_W-1:0] MUX_LAST = 2'h3;
    localparam logic [MUX_W-1:0] MUX_SERIAL = 2'h3;
    localparam logic [ID_W-1:0] DIAG_ID_OFS = 11'h001;
    // remote mode lengthens the period by 20 %
    localparam int STRETCH_NUM = 6;
    localparam int STRETCH_DEN = 5;
    localparam int POLL_US = 1000;
    typedef logic [7:0][TMR_W-1:0] pmc_rate_tbl_t;
    // periods in microseconds, index = rate code
    localparam pmc_rate_tbl_t DATA_US_DFLT = {24'd100000, 24'd50000, 24'd20000, 24'd10000,
                                              24'd5000, 24'd2000, 24'd1000, 24'd1000};
    localparam pmc_rate_tbl_t DIAG_US_DFLT = {24'd1000000, 24'd1000000, 24'd1000000,
                                              24'd1000000, 24'd1000000, 24'd1000000,
                                              24'd1000000, 24'd1000000};
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_DATA = 2'b01, TX_DIAG = 2'b11} pmc_tx_t;
    typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_CFG = 2'b01, HS_POLL = 2'b11} pmc_hs_t;
endpackage

// >>> pmc_link_if.sv
`timescale 1ns/1ps
interface pmc_link_if;
    import pmc_pkg::*;
    logic h2d_valid;
    logic h2d_ready;
    logic [ID_W-1:0] h2d_id;
    logic h2d_rtr;
    logic [DATA_W-1:0] h2d_data;
    logic d2h_valid;
    logic d2h_ready;
    logic [ID_W-1:0] d2h_id;
    logic [DATA_W-1:0] d2h_data;
    modport dev (input h2d_valid, output h2d_ready, input h2d_id, input h2d_rtr,
                 input h2d_data, output d2h_valid, input d2h_ready, output d2h_id,
                 output d2h_data);
    modport host (output h2d_valid, input h2d_ready, output h2d_id, output h2d_rtr,
                  output h2d_data, input d2h_valid, output d2h_ready, input d2h_id,
                  input d2h_data);
endinterface

// >>> pmc_host.sv
`timescale 1ns/1ps
module pmc_host
    import pmc_pkg::*;
#(
    parameter int POLL_PERIOD_US = POLL_US
) (
    input wire logic clk,
    input wire logic reset_n,
    pmc_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [SER_W-1:0] cmd_serial,
    input wire logic cmd_diag_en,
    input wire logic cmd_rtr_en,
    input wire logic [RATE_W-1:0] cmd_rate,
    input wire logic [ID_W-1:0] cmd_base,
    input wire logic [ID_W-1:0] default_config_identifier,
    output logic rx_valid,
    output logic [ID_W-1:0] rx_id,
    output logic [DATA_W-1:0] rx_data
);
    pmc_hs_t st_r;
    pmc_hs_t st_nxt;
    logic [TICK_W-1:0] tick_r;
    logic [TMR_W-1:0] pt_r;
    logic poll_on_r;
    logic poll_pend_r;
    logic [ID_W-1:0] poll_id_r;
    logic [ID_W-1:0] tx_id_r;
    logic tx_rtr_r;
    logic [DATA_W-1:0] tx_data_r;
    logic rx_valid_r;
    logic [ID_W-1:0] rx_id_r;
    logic [DATA_W-1:0] rx_data_r;

    wire tick = (tick_r == TICK_LAST);
    wire poll_due = poll_on_r && tick && (pt_r >= TMR_W'(POLL_PERIOD_US - 1));
    wire tx_fire = link.h2d_valid && link.h2d_ready;
    // one configuration frame at a time, units taken in turn
    assign cmd_ready = (st_r == HS_IDLE);
    wire cfg_go = cmd_valid && cmd_ready;
    wire poll_go = (st_r == HS_IDLE) && !cfg_go && poll_pend_r;
    wire [7:0] cfg_byte = {3'h0, cmd_rate, cmd_rtr_en, cmd_diag_en};
    wire [DATA_W-1:0] cfg_frame = {8'h00, 5'h00, cmd_base[10:8], cmd_base[7:0], cfg_byte,
                                   cmd_serial};

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            HS_IDLE:
            begin
                if (cfg_go)
                    st_nxt = HS_CFG;
                else if (poll_go)
                    st_nxt = HS_POLL;
            end
            HS_CFG,
            HS_POLL:
            begin
                if (tx_fire)
                    st_nxt = HS_IDLE;
            end
            default:
                st_nxt = HS_IDLE;
        endcase
    end

    assign link.h2d_valid = (st_r != HS_IDLE);
    assign link.h2d_id = tx_id_r;
    assign link.h2d_rtr = tx_rtr_r;
    assign link.h2d_data = tx_data_r;
    assign link.d2h_ready = 1'b1;
    assign rx_valid = rx_valid_r;
    assign rx_id = rx_id_r;
    assign rx_data = rx_data_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= HS_IDLE;
            tx_id_r <= '0;
            tx_rtr_r <= 1'b0;
            tx_data_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            if (cfg_go)
            begin
                tx_id_r <= default_config_identifier;
                tx_rtr_r <= 1'b0;
                tx_data_r <= cfg_frame;
            end
            else if (poll_go)
            begin
                tx_id_r <= poll_id_r;
                tx_rtr_r <= 1'b1;
                tx_data_r <= '0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_r <= '0;
            pt_r <= '0;
            poll_on_r <= 1'b0;
            poll_pend_r <= 1'b0;
            poll_id_r <= '0;
        end
        else
        begin
            tick_r <= tick ? '0 : tick_r + 1'b1;
            if (poll_due || cfg_go)
                pt_r <= '0;
            else if (tick)
                pt_r <= pt_r + 1'b1;
            if (cfg_go)
            begin
                poll_on_r <= cmd_rtr_en;
                poll_id_r <= cmd_base;
            end
            poll_pend_r <= poll_due || (poll_pend_r && !poll_go);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_valid_r <= 1'b0;
            rx_id_r <= '0;
            rx_data_r <= '0;
        end
        else
        begin
            rx_valid_r <= link.d2h_valid;
            if (link.d2h_valid)
            begin
                rx_id_r <= link.d2h_id;
                rx_data_r <= link.d2h_data;
            end
        end
    end
endmodule

// >>> pmc_link_chk.sv
`timescale 1ns/1ps
module pmc_link_chk
    import pmc_pkg::*;
#(
    parameter logic [ID_W-1:0] CFG_ID = CFG_ID_DFLT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic h2d_valid,
    input wire logic h2d_ready,
    input wire logic [ID_W-1:0] h2d_id,
    input wire logic h2d_rtr,
    input wire logic [DATA_W-1:0] h2d_data,
    input wire logic d2h_valid,
    input wire logic d2h_ready,
    input wire logic [ID_W-1:0] d2h_id,
    input wire logic [DATA_W-1:0] d2h_data
);
    logic cfg_seen_r;
    logic set_seen_r;
    logic coh_r;
    wire logic cfg_take = h2d_valid && !h2d_rtr && h2d_id == CFG_ID;
    wire logic set_start = d2h_valid && d2h_data[1:0] == 2'h0;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_seen_r <= 1'b0;
            set_seen_r <= 1'b0;
            coh_r <= 1'b0;
        end
        else
        begin
            cfg_seen_r <= cfg_seen_r | cfg_take;
            set_seen_r <= set_seen_r | set_start;
            if (set_start)
                coh_r <= d2h_data[COH_BIT];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_h2d_ready;
        h2d_ready;
    endproperty
    a_h2d_ready: assert property (p_h2d_ready) else $error("host frame refused");
    property p_d2h_ready;
        d2h_ready;
    endproperty
    a_d2h_ready: assert property (p_d2h_ready) else $error("device frame refused");
    property p_h2d_gap;
        h2d_valid |=> !h2d_valid;
    endproperty
    a_h2d_gap: assert property (p_h2d_gap) else $error("host frames too close");
    property p_cfg_spare;
        cfg_take |-> h2d_data[63:51] == 13'h0 && h2d_data[39:37] == 3'h0;
    endproperty
    a_cfg_spare: assert property (p_cfg_spare) else $error("spare bits set");
    property p_quiet;
        !cfg_seen_r |-> !d2h_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("frame before configuration");
    property p_d2h_gap;
        d2h_valid |=> !d2h_valid;
    endproperty
    a_d2h_gap: assert property (p_d2h_gap) else $error("device frames too close");
    property p_set_order;
        d2h_valid && d2h_data[1:0] != 2'h3 |=> !d2h_valid ##1 d2h_valid
            && d2h_data[1:0] == $past(d2h_data[1:0], 2) + 2'h1
            && d2h_id == $past(d2h_id, 2) && d2h_data[COH_BIT] == $past(d2h_data[COH_BIT], 2);
    endproperty
    a_set_order: assert property (p_set_order) else $error("set order broken");
    property p_coh_flip;
        set_start && set_seen_r |-> d2h_data[COH_BIT] != coh_r;
    endproperty
    a_coh_flip: assert property (p_coh_flip) else $error("coherency not toggled");
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import pmc_pkg::*;
    localparam pmc_rate_tbl_t DATA_T = {24'h28, 24'h23, 24'h1e, 24'h19, 24'h14, 24'hf, 24'ha,
                                        24'h5};
    localparam pmc_rate_tbl_t DIAG_T = {8{24'h64}};
    localparam int POLL = 10;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic samp_valid = 1'b0;
    logic samp_ready;
    logic [DATA_W-1:0] samp_data = '0;
    logic [DATA_W-1:0] diag_data = '0;
    logic [SER_W-1:0] own_serial = '0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic [SER_W-1:0] cmd_serial = '0;
    logic cmd_diag_en = 1'b0;
    logic cmd_rtr_en = 1'b0;
    logic [RATE_W-1:0] cmd_rate = '0;
    logic [ID_W-1:0] cmd_base = '0;
    logic rx_valid;
    logic [ID_W-1:0] rx_id;
    logic [DATA_W-1:0] rx_data;
    logic configured;
    logic [ID_W-1:0] global_data_identifier;
    logic feed = 1'b0;
    logic took = 1'b0;
    logic coh = 1'b0;
    logic exp_diag = 1'b0;
    logic [ID_W-1:0] exp_base = '0;
    logic [31:0] seed = 32'h1e;
    logic [DATA_W-1:0] q[$];
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int mux = 0;
    int n_set = 0;
    int n_diag = 0;
    int t_prev = 0;
    int t_last = 0;
    always #25 clk = ~clk;
    pmc_link_if link ();
    pmc_device #(.DATA_US(DATA_T), .DIAG_US(DIAG_T)) u_pmc_device (
        .clk(clk), .reset_n(reset_n), .link(link.dev), .default_config_identifier(CFG_ID_DFLT),
        .own_serial(own_serial), .samp_valid(samp_valid), .samp_ready(samp_ready),
        .samp_data(samp_data), .diag_data(diag_data), .sample_start(), .configured(configured),
        .global_data_identifier(global_data_identifier));
    pmc_host #(.POLL_PERIOD_US(POLL)) u_pmc_host (
        .clk(clk), .reset_n(reset_n), .link(link.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_serial(cmd_serial), .cmd_diag_en(cmd_diag_en),
        .cmd_rtr_en(cmd_rtr_en), .cmd_rate(cmd_rate), .cmd_base(cmd_base),
        .default_config_identifier(CFG_ID_DFLT), .rx_valid(rx_valid), .rx_id(rx_id),
        .rx_data(rx_data));
    pmc_link_chk u_pmc_link_chk (
        .clk(clk), .reset_n(reset_n), .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready),
        .h2d_id(link.h2d_id), .h2d_rtr(link.h2d_rtr), .h2d_data(link.h2d_data),
        .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready), .d2h_id(link.d2h_id),
        .d2h_data(link.d2h_data));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // reference model of the frame stream seen by the host
    task automatic frame_in();
        logic [DATA_W-1:0] w;
        w = '1;
        if (rx_id === exp_base + DIAG_ID_OFS)
        begin
            n_diag++;
            check("diag enable", 1, exp_diag);
            check("diag frame", diag_data, rx_data);
        end
        else
        begin
            if (q.size() > 0)
                w = q.pop_front();
            w[MUX_W-1:0] = MUX_W'(mux);
            w[COH_BIT] = coh;
            if (mux == 3)
                w[SERIAL_LSB +: SER_W] = own_serial;
            if (mux == 0)
            begin
                t_prev = t_last;
                t_last = cyc;
                n_set++;
            end
            check("data id", exp_base, rx_id);
            check("data frame", w, rx_data);
            mux = (mux + 1) % 4;
            if (mux == 0)
                coh = ~coh;
        end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            final_report();
        end
        took <= samp_valid && samp_ready;
        if (samp_valid && samp_ready)
            q.push_back(samp_data);
        if (rx_valid === 1'b1)
            frame_in();
    end
    // sample source holds each word until the fifo takes it
    always @(negedge clk)
    begin
        if (took || !samp_valid)
        begin
            samp_valid <= feed;
            samp_data <= {rnd(), rnd()};
        end
    end
    task automatic send_cfg(input logic [SER_W-1:0] s, input logic d, input logic r,
                            input logic [RATE_W-1:0] rate, input logic [ID_W-1:0] b);
        int n;
        @(negedge clk);
        cmd_serial = s;
        cmd_diag_en = d;
        cmd_rtr_en = r;
        cmd_rate = rate;
        cmd_base = b;
        cmd_valid = 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 50);
        @(negedge clk);
        cmd_valid = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    task automatic period(input int e, input string what);
        int n0;
        n0 = n_set;
        while (n_set < n0 + 3)
            @(negedge clk);
        check(what, e, t_last - t_prev);
    endtask
    initial
    begin
        logic [ID_W-1:0] b;
        own_serial = rnd() | 32'h1;
        diag_data = {rnd(), rnd() | 32'h3};
        b = ID_W'(rnd());
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        feed = 1'b1;
        repeat (30) @(negedge clk);
        check("fifo ready when full", 0, samp_ready);
        check("fifo words", FIFO_DEPTH, q.size());
        check("configured early", 0, configured);
        check("early frames", 0, n_set);
        $display("test fill done");
        send_cfg(own_serial ^ 32'h1, 1'b1, 1'b0, 3'h0, b);
        check("wrong serial", 0, configured);
        $display("test serial filter done");
        exp_base = b;
        exp_diag = 1'b1;
        send_cfg(32'h0, 1'b1, 1'b0, 3'h0, b);
        check("zero serial", 1, configured);
        check("base id", b, global_data_identifier);
        for (int r = 0; r < 8; r++)
        begin
            send_cfg(own_serial, 1'b1, 1'b0, 3'(r), b);
            period(DATA_T[r] * 20, "data period");
        end
        check("diag frames", 1, n_diag > 0);
        $display("test rates done");
        send_cfg(32'h0, 1'b0, 1'b0, 3'h0, b ^ 11'h1);
        check("zero serial late", b, global_data_identifier);
        send_cfg(own_serial, 1'b0, 1'b1, 3'h7, b);
        period(POLL * 20, "poll period");
        exp_diag = 1'b0;
        $display("test remote done");
        send_cfg(own_serial ^ 32'h1, 1'b0, 1'b0, 3'h7, b);
        period(DATA_T[7] * 24, "fallback period");
        $display("test fallback done");
        feed = 1'b0;
        final_report();
    end
endmodule
